// ==== pmc_monitor.v ====
// What this block does
// - three event counters plus cycle counter
// - each counter follows its own code
// - code 00 counts software increments
// - codes 01,03,04 count cache events
// - codes 06,07 count data reads/writes
// - codes 08,5e count instructions, dual pairs
// - codes 09,0a count exceptions and returns
// - codes 0b,0c context change, pc write
// - code 0d counts immediate branches, untaken too
// - codes 0e,0f procedure returns, unaligned
// - code 10 counts branch mispredicts
// - code 11 counts every clock cycle
// - user access honoured only when granted
// - reset clears counters, count while enabled
// - reads return the selected counter
// - stop-all halts the three event counters, keeps values; cycle counter runs on
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.vh"

module pmc_monitor #(
  parameter W = 32
) (
  // clock and reset
  input  wire         i_ref_clk,
  input  wire         i_sys_rst,
  // privilege
  input  wire         i_priv,
  input  wire         i_user_grant,
  input  wire         i_user_revoke,
  // global commands
  input  wire         i_cnt_reset,
  input  wire         i_global_en,
  input  wire         i_global_dis,
  input  wire         i_stop_all,
  // per counter commands
  input  wire [1:0]   i_sel,
  input  wire         i_select,
  input  wire         i_start,
  input  wire [7:0]   i_start_code,
  input  wire [W-1:0] i_start_val,
  input  wire         i_stop,
  input  wire         i_sw_inc,
  input  wire         i_read,
  // event sources
  input  wire         i_icache_miss,
  input  wire         i_dcache_miss,
  input  wire         i_dcache_access,
  input  wire         i_data_read,
  input  wire         i_data_write,
  input  wire         i_instr_executed,
  input  wire         i_dual_issue,
  input  wire         i_exception_taken,
  input  wire         i_exception_return,
  input  wire         i_context_change,
  input  wire         i_pc_write,
  input  wire         i_imm_branch,
  input  wire         i_procedure_return,
  input  wire         i_unaligned_access,
  input  wire         i_branch_mispredict,
  // status and data
  output reg  [W-1:0] o_rdata,
  output reg          o_rvalid,
  output reg          o_denied,
  output reg          o_user_ok,
  output reg          o_global_on,
  output reg  [2:0]   o_run,
  output reg  [1:0]   o_cur_sel
);

  reg  [7:0]   code_q [0:2];
  reg          user_ok_q;
  reg          user_ok_d;
  reg          gen_q;
  reg          gen_d;
  reg  [2:0]   run_q;
  reg  [1:0]   sel_q;
  reg  [1:0]   sel_d;
  reg  [W-1:0] cyc_q;
  reg  [W-1:0] cyc_d;
  wire [W-1:0] cnt [0:2];
  wire [2:0]   hit;
  wire         allowed;
  wire         req;
  wire         clr_all;

  assign allowed = i_priv | user_ok_q;
  // any command pulse, used only for the refusal flag
  assign req     = i_user_grant
                 | i_user_revoke
                 | i_cnt_reset
                 | i_global_en
                 | i_global_dis
                 | i_stop_all
                 | i_select
                 | i_start
                 | i_stop
                 | i_sw_inc
                 | i_read;
  assign clr_all = allowed & i_cnt_reset;

  // permission only moves under privilege; grant wins a tie
  always @* begin
    user_ok_d = user_ok_q;
    if (i_priv && i_user_grant) begin
      user_ok_d = 1'b1;
    end else if (i_priv && i_user_revoke) begin
      user_ok_d = 1'b0;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      user_ok_q <= 1'b0;
    end else begin
      user_ok_q <= user_ok_d;
    end
  end

  // global enable, enable wins a tie
  always @* begin
    gen_d = gen_q;
    if (allowed && i_global_en) begin
      gen_d = 1'b1;
    end else if (allowed && i_global_dis) begin
      gen_d = 1'b0;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      gen_q <= 1'b0;
    end else begin
      gen_q <= gen_d;
    end
  end

  always @* begin
    sel_d = sel_q;
    if (allowed && i_select) begin
      sel_d = i_sel;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sel_q <= `PMC_SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_cnt
      wire this_sel;
      wire this_start;
      // widen the index rather than slice the loop variable
      assign this_sel   = allowed && ({30'h0000_0000, i_sel} == g);
      // stop-all beats a start in the same cycle
      assign this_start = this_sel && i_start && !i_stop_all;

      always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
          code_q[g] <= `PMC_EVT_RST;
          run_q[g]  <= 1'b0;
        end else if (allowed && i_stop_all) begin
          run_q[g]  <= 1'b0;
        end else if (this_sel && i_start) begin
          code_q[g] <= i_start_code;
          run_q[g]  <= 1'b1;
        end else if (this_sel && i_stop) begin
          run_q[g]  <= 1'b0;
        end
      end

      // software increment reaches only the addressed counter
      pmc_event_mux u_mux (
        .i_code              (code_q[g]),
        .i_sw_inc            (this_sel && i_sw_inc),
        .i_icache_miss       (i_icache_miss),
        .i_dcache_miss       (i_dcache_miss),
        .i_dcache_access     (i_dcache_access),
        .i_data_read         (i_data_read),
        .i_data_write        (i_data_write),
        .i_instr_executed    (i_instr_executed),
        .i_dual_issue        (i_dual_issue),
        .i_exception_taken   (i_exception_taken),
        .i_exception_return  (i_exception_return),
        .i_context_change    (i_context_change),
        .i_pc_write          (i_pc_write),
        .i_imm_branch        (i_imm_branch),
        .i_procedure_return  (i_procedure_return),
        .i_unaligned_access  (i_unaligned_access),
        .i_branch_mispredict (i_branch_mispredict),
        .o_hit               (hit[g])
      );

      pmc_event_counter #(.W(W)) u_cnt (
        .i_ref_clk  (i_ref_clk),
        .i_sys_rst  (i_sys_rst),
        .i_clear    (clr_all),
        .i_load     (this_start),
        .i_load_val (i_start_val),
        .i_run      (gen_q && run_q[g]),
        .i_hit      (hit[g]),
        .o_count    (cnt[g])
      );
    end
  endgenerate

  // dedicated cycle counter
  // wraps silently; software must read before roll-over
  always @* begin
    cyc_d = cyc_q;
    if (clr_all) begin
      cyc_d = `PMC_CNT_RST;
    end else if (gen_q) begin
      cyc_d = cyc_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cyc_q <= `PMC_CNT_RST;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  // selected counter value, held until next read
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rdata <= {W{1'b0}};
    end else if (allowed && i_read) begin
      case (sel_q)
        2'h0:           o_rdata <= cnt[0];
        2'h1:           o_rdata <= cnt[1];
        2'h2:           o_rdata <= cnt[2];
        `PMC_SEL_CYCLE: o_rdata <= cyc_q;
        default:        o_rdata <= {W{1'b0}};
      endcase
    end
  end

  // one-cycle answer strobe
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= allowed && i_read;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_denied <= 1'b0;
    end else begin
      o_denied <= req && !allowed;
    end
  end

  // status mirrors lag the state by one cycle
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_user_ok <= 1'b0;
    end else begin
      o_user_ok <= user_ok_q;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_global_on <= 1'b0;
    end else begin
      o_global_on <= gen_q;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_run <= 3'h0;
    end else begin
      o_run <= run_q;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_cur_sel <= `PMC_SEL_RST;
    end else begin
      o_cur_sel <= sel_q;
    end
  end

endmodule
`default_nettype wire

// ==== pmc_map.vh ====
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// event codes
`define PMC_EVT_SW_INCREMENT       8'h00
`define PMC_EVT_ICACHE_MISS        8'h01
`define PMC_EVT_DCACHE_MISS        8'h03
`define PMC_EVT_DCACHE_ACCESS      8'h04
`define PMC_EVT_DATA_READ          8'h06
`define PMC_EVT_DATA_WRITE         8'h07
`define PMC_EVT_INSTR_EXECUTED     8'h08
`define PMC_EVT_EXCEPTION_TAKEN    8'h09
`define PMC_EVT_EXCEPTION_RETURN   8'h0a
`define PMC_EVT_CONTEXT_CHANGE     8'h0b
`define PMC_EVT_PC_WRITE           8'h0c
`define PMC_EVT_IMM_BRANCH         8'h0d
`define PMC_EVT_PROCEDURE_RETURN   8'h0e
`define PMC_EVT_UNALIGNED_ACCESS   8'h0f
`define PMC_EVT_BRANCH_MISPREDICT  8'h10
`define PMC_EVT_CYCLE_TICK         8'h11
`define PMC_EVT_DUAL_ISSUE         8'h5e

// reset values
`define PMC_CNT_RST                32'h0000_0000
`define PMC_EVT_RST                8'h00
`define PMC_SEL_RST                2'h0

// index of the cycle counter on the read select
`define PMC_SEL_CYCLE              2'h3

`endif

// ==== pmc_event_mux.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.vh"

module pmc_event_mux (
  // event code
  input  wire [7:0]  i_code,
  // event sources
  input  wire        i_sw_inc,
  input  wire        i_icache_miss,
  input  wire        i_dcache_miss,
  input  wire        i_dcache_access,
  input  wire        i_data_read,
  input  wire        i_data_write,
  input  wire        i_instr_executed,
  input  wire        i_dual_issue,
  input  wire        i_exception_taken,
  input  wire        i_exception_return,
  input  wire        i_context_change,
  input  wire        i_pc_write,
  input  wire        i_imm_branch,
  input  wire        i_procedure_return,
  input  wire        i_unaligned_access,
  input  wire        i_branch_mispredict,
  // selected event
  output reg         o_hit
);

  always @* begin
    case (i_code)
      `PMC_EVT_SW_INCREMENT:      o_hit = i_sw_inc;
      `PMC_EVT_ICACHE_MISS:       o_hit = i_icache_miss;
      `PMC_EVT_DCACHE_MISS:       o_hit = i_dcache_miss;
      `PMC_EVT_DCACHE_ACCESS:     o_hit = i_dcache_access;
      `PMC_EVT_DATA_READ:         o_hit = i_data_read;
      `PMC_EVT_DATA_WRITE:        o_hit = i_data_write;
      `PMC_EVT_INSTR_EXECUTED:    o_hit = i_instr_executed;
      `PMC_EVT_DUAL_ISSUE:        o_hit = i_dual_issue;
      `PMC_EVT_EXCEPTION_TAKEN:   o_hit = i_exception_taken;
      `PMC_EVT_EXCEPTION_RETURN:  o_hit = i_exception_return;
      `PMC_EVT_CONTEXT_CHANGE:    o_hit = i_context_change;
      `PMC_EVT_PC_WRITE:          o_hit = i_pc_write;
      `PMC_EVT_IMM_BRANCH:        o_hit = i_imm_branch;
      `PMC_EVT_PROCEDURE_RETURN:  o_hit = i_procedure_return;
      `PMC_EVT_UNALIGNED_ACCESS:  o_hit = i_unaligned_access;
      `PMC_EVT_BRANCH_MISPREDICT: o_hit = i_branch_mispredict;
      `PMC_EVT_CYCLE_TICK:        o_hit = 1'b1;
      default:                    o_hit = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ==== pmc_event_counter.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.vh"

module pmc_event_counter #(
  parameter W = 32
) (
  // clock and reset
  input  wire         i_ref_clk,
  input  wire         i_sys_rst,
  // control
  input  wire         i_clear,
  input  wire         i_load,
  input  wire [W-1:0] i_load_val,
  input  wire         i_run,
  input  wire         i_hit,
  // count
  output wire [W-1:0] o_count
);

  reg [W-1:0] cnt_q;

  always @(posedge i_ref_clk) begin
    if (i_sys_rst || i_clear) begin
      cnt_q <= {W{1'b0}};
    end else if (i_load) begin
      cnt_q <= i_load_val;
    end else if (i_run && i_hit) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_count = cnt_q;

endmodule
`default_nettype wire

// ==== pmc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmc_checker #(
  parameter W = 32
) (
  // watched ports
  input wire logic         i_ref_clk,
  input wire logic         i_sys_rst,
  input wire logic         i_priv,
  input wire logic         i_user_grant,
  input wire logic         i_global_en,
  input wire logic         i_stop_all,
  input wire logic         i_select,
  input wire logic [1:0]   i_sel,
  input wire logic         i_read,
  input wire logic [W-1:0] o_rdata,
  input wire logic         o_rvalid,
  input wire logic         o_denied,
  input wire logic         o_user_ok,
  input wire logic [1:0]   o_cur_sel,
  input wire logic         o_global_on,
  input wire logic [2:0]   o_run
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  property p_rst_out;
    $fell(i_sys_rst) |-> !o_rvalid && !o_global_on && o_run == 3'h0;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("status set after reset");
  property p_rd_ans;
    i_priv && i_read |=> o_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_hold;
    !o_rvalid |-> $stable(o_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // lagging status: a grant one cycle back is not yet visible
  property p_deny;
    !i_priv && !o_user_ok && !$past(i_user_grant) && i_read |=> o_denied && !o_rvalid;
  endproperty
  a_deny: assert property (p_deny) else $error("user read not refused");
  property p_grant;
    i_priv && i_user_grant |-> ##[1:2] o_user_ok;
  endproperty
  a_grant: assert property (p_grant) else $error("grant not shown");
  property p_gon;
    i_priv && i_global_en |-> ##[1:2] o_global_on;
  endproperty
  a_gon: assert property (p_gon) else $error("enable not shown");
  property p_stop;
    i_priv && i_stop_all |-> ##[1:2] (o_run == 3'h0);
  endproperty
  a_stop: assert property (p_stop) else $error("stop all left a counter running");
  property p_sel;
    i_priv && i_select && i_sel == 2'h2 |-> ##2 o_cur_sel == 2'h2;
  endproperty
  a_sel: assert property (p_sel) else $error("select not latched");
endmodule
bind pmc_monitor pmc_checker #(.W(W)) u_chk (
  .i_ref_clk    (i_ref_clk),
  .i_sys_rst    (i_sys_rst),
  .i_priv       (i_priv),
  .i_user_grant (i_user_grant),
  .i_global_en  (i_global_en),
  .i_stop_all   (i_stop_all),
  .i_select     (i_select),
  .i_sel        (i_sel),
  .i_read       (i_read),
  .o_rdata      (o_rdata),
  .o_rvalid     (o_rvalid),
  .o_denied     (o_denied),
  .o_user_ok    (o_user_ok),
  .o_cur_sel    (o_cur_sel),
  .o_global_on  (o_global_on),
  .o_run        (o_run)
);
`default_nettype wire

// ==== pmc_event_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmc_event_src (
  // burst request
  input  wire logic        i_ref_clk,
  input  wire logic        i_fire,
  input  wire logic [3:0]  i_which,
  input  wire logic [3:0]  i_n,
  input  wire logic        i_slow,
  // event pulses
  output logic      [14:0] o_ev,
  output logic             o_busy
);
  logic [14:0] ev_q = 15'h0;
  logic [3:0]  n_q = 4'h0;
  logic [3:0]  w_q = 4'h0;
  logic        s_q = 1'b0;
  logic        gap_q = 1'b0;
  assign o_ev = ev_q;
  assign o_busy = n_q != 4'h0;
  always @(posedge i_ref_clk) begin
    ev_q <= 15'h0;
    if (i_fire) begin
      n_q <= i_n;
      w_q <= i_which;
      s_q <= i_slow;
      gap_q <= 1'b0;
    end else if (o_busy) begin
      // slow mode leaves an idle cycle between events
      gap_q <= s_q & ~gap_q;
      if (!gap_q) begin
        ev_q[w_q] <= 1'b1;
        n_q <= n_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test_cpu_event_counter_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_cpu_event_counter_monitor;
  localparam RG = 0, RV = 1, CR = 2, GE = 3, GD = 4, SA = 5, SL = 6, SR = 7, SP = 8, SI = 9;
  localparam RD = 10;
  logic        i_ref_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_priv = 1'b1;
  logic [10:0] st = 11'h0;
  logic [1:0]  i_sel = 2'h0;
  logic [7:0]  i_start_code = 8'h0;
  logic [31:0] i_start_val = 32'h0;
  logic        i_fire = 1'b0;
  logic [3:0]  i_which = 4'h0;
  logic [3:0]  i_n = 4'h0;
  logic        i_slow = 1'b0;
  wire  [14:0] o_ev;
  wire         o_busy;
  wire  [31:0] o_rdata;
  wire  [2:0]  o_run;
  wire  [1:0]  o_cur_sel;
  wire         o_rvalid, o_denied, o_user_ok, o_global_on;
  wire         i_user_grant, i_user_revoke, i_cnt_reset, i_global_en, i_global_dis;
  wire         i_stop_all, i_select, i_start, i_stop, i_sw_inc, i_read;
  int          n_errors = 0;
  int          num_checks = 0;
  logic [7:0]  codes [15] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h5e, 8'h09,
                              8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
  assign {i_read, i_sw_inc, i_stop, i_start, i_select, i_stop_all, i_global_dis,
          i_global_en, i_cnt_reset, i_user_revoke, i_user_grant} = st;
  pmc_event_src u_src (.*);
  pmc_monitor dut (.*, .i_icache_miss(o_ev[0]), .i_dcache_miss(o_ev[1]),
    .i_dcache_access(o_ev[2]), .i_data_read(o_ev[3]), .i_data_write(o_ev[4]),
    .i_instr_executed(o_ev[5]), .i_dual_issue(o_ev[6]), .i_exception_taken(o_ev[7]),
    .i_exception_return(o_ev[8]), .i_context_change(o_ev[9]), .i_pc_write(o_ev[10]),
    .i_imm_branch(o_ev[11]), .i_procedure_return(o_ev[12]),
    .i_unaligned_access(o_ev[13]), .i_branch_mispredict(o_ev[14]));
  initial forever #25 i_ref_clk = ~i_ref_clk;
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task go(input int b, input int s = 0, input logic [7:0] c = 0, input logic [31:0] v = 0);
    @(posedge i_ref_clk);
    st <= 11'h1 << b;
    i_sel <= 2'(s);
    i_start_code <= c;
    i_start_val <= v;
    @(posedge i_ref_clk);
    st <= 11'h0;
  endtask
  task rd(input int s, output logic [31:0] d);
    go(SL, s);
    go(RD);
    @(negedge i_ref_clk);
    chk("rvalid", o_rvalid, 1);
    d = o_rdata;
  endtask
  // reads taken exactly ten edges apart
  task rpair(input int s, output logic [31:0] d);
    logic [31:0] a;
    rd(s, a);
    repeat (8) @(posedge i_ref_clk);
    go(RD);
    @(negedge i_ref_clk);
    d = o_rdata - a;
  endtask
  task fire_ev(input int w, input int n, input bit sl);
    @(posedge i_ref_clk);
    i_fire <= 1'b1;
    i_which <= 4'(w);
    i_n <= 4'(n);
    i_slow <= sl;
    @(posedge i_ref_clk);
    i_fire <= 1'b0;
    for (int k = 0; k < 40 && (k < 2 || o_busy); k++) @(negedge i_ref_clk);
    if (o_busy) begin
      chk("source hung", o_busy, 0);
      close_out;
    end
  endtask
  task t_init;
    @(negedge i_ref_clk);
    chk("run", o_run, 0);
    go(CR);
    go(GE);
    repeat (2) @(negedge i_ref_clk);
    chk("global on", o_global_on, 1);
  endtask
  task t_codes;
    logic [31:0] d;
    for (int i = 0; i < 15; i++) begin
      go(SR, i % 3, codes[i], 32'd100);
      fire_ev(i, 3, i[0]);
      fire_ev((i + 1) % 15, 2, 0);
      go(SP, i % 3);
      rd(i % 3, d);
      chk("event count", d, 32'd103);
      chk("current index", o_cur_sel, i % 3);
    end
  endtask
  task t_sw;
    logic [31:0] d;
    go(SR, 1, 8'h00, 32'hffff_fffe);
    fire_ev(5, 4, 0);
    go(SI, 1);
    go(SI, 1);
    go(SP, 1);
    rd(1, d);
    chk("sw increment wrap", d, 32'h0);
    go(SR, 2, 8'h02, 32'd7);
    fire_ev(0, 4, 0);
    fire_ev(14, 4, 1);
    go(SP, 2);
    rd(2, d);
    chk("unknown code", d, 32'd7);
  endtask
  task t_rst;
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_ref_clk);
    chk("global after reset", o_global_on, 0);
    chk("rdata after reset", o_rdata, 0);
    t_init;
  endtask
  task t_cycle;
    logic [31:0] d;
    go(SR, 0, 8'h11, 32'h0);
    rpair(0, d);
    chk("cycle code", d, 32'd10);
    rpair(3, d);
    chk("cycle counter", d, 32'd10);
    go(SA);
    repeat (2) @(negedge i_ref_clk);
    chk("run after stop all", o_run, 0);
    rpair(0, d);
    chk("stopped count", d, 0);
    go(GD);
    rpair(3, d);
    chk("disabled count", d, 0);
    go(CR);
    rd(0, d);
    chk("cleared", d, 0);
  endtask
  task t_user;
    logic [31:0] d;
    @(posedge i_ref_clk);
    i_priv <= 1'b0;
    go(RD);
    @(negedge i_ref_clk);
    chk("denied", o_denied, 1);
    chk("no answer", o_rvalid, 0);
    @(posedge i_ref_clk);
    i_priv <= 1'b1;
    go(RG);
    i_priv <= 1'b0;
    rd(0, d);
    chk("user ok", o_user_ok, 1);
    @(posedge i_ref_clk);
    i_priv <= 1'b1;
    go(RV);
    i_priv <= 1'b0;
    go(RD);
    @(negedge i_ref_clk);
    chk("denied after revoke", o_denied, 1);
    @(posedge i_ref_clk);
    i_priv <= 1'b1;
  endtask
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    t_init;
    t_codes;
    t_sw;
    t_rst;
    t_cycle;
    t_user;
    close_out;
  end
endmodule
`default_nettype wire
